// ---- ext_bus_pkg.sv ----
package ext_bus_pkg;

  // ***************************************************************
  // Register map (index on the register port)
  // ***************************************************************
  localparam logic [1:0] REG_EXT_BUS_CONTROL = 2'h0;
  localparam logic [1:0] REG_PORT_PULLUP_CONFIG = 2'h1;
  localparam logic [1:0] REG_MODULE_POWER_DISABLE_FOUR = 2'h2;

  // ***************************************************************
  // Field layouts, implemented-bit masks and reset values
  // ***************************************************************
  localparam int BUS_DISABLE_BIT = 7;
  localparam int WAIT_COUNT_LSB = 4;
  localparam int WAIT_COUNT_W = 2;
  localparam int WRITE_CFG_LSB = 0;
  localparam int WRITE_CFG_W = 2;
  localparam int MEMBUS_MODULE_OFF_BIT = 0;
  localparam logic [7:0] EXT_BUS_CONTROL_MASK = 8'hB3;
  localparam logic [7:0] PORT_PULLUP_CONFIG_MASK = 8'hFF;
  localparam logic [7:0] MODULE_POWER_DISABLE_FOUR_MASK = 8'hFD;
  localparam logic [7:0] EXT_BUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_PULLUP_CONFIG_RESET = 8'h00;
  localparam logic [7:0] MODULE_POWER_DISABLE_FOUR_RESET = 8'h00;

  // ***************************************************************
  // Write configurations for sixteen-bit data width
  // ***************************************************************
  localparam logic [1:0] WCFG_BYTE_WRITE = 2'h0;
  localparam logic [1:0] WCFG_WORD_WRITE = 2'h1;
  localparam logic [1:0] WCFG_BYTE_SELECT = 2'h2;

  // ***************************************************************
  // Timing constants
  // ***************************************************************
  localparam int READ_SYNC_CYCLES = 2;
  localparam int ADDR_PHASE_CYCLES = 1;

  // Core power modes
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_RUN_REDUCED,
    MODE_IDLE,
    MODE_SLEEP
  } power_mode_t;

  // Bus cycle states
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_DATA
  } bus_state_t;

endpackage : ext_bus_pkg

// ---- input_sync.sv ----
`timescale 1ns/10ps
module input_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // Two flip-flops; only the second stage reads the first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule : input_sync

// ---- phase_timer.sv ----
`timescale 1ns/10ps
module phase_timer #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic hold,
  // Status
  output logic expired
);

  logic [WIDTH-1:0] count;

  // Counts down the remaining cycles of a phase; hold freezes it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (!hold && count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign expired = (count == '0);

endmodule : phase_timer

// ---- ext_bus_power_mode_control.sv ----
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// What this block does
// - In the reduced-speed run mode bus cycles go on normally, timed by the current core clock.
// - In sleep or idle no new bus transaction is started until the mode is left.
// - In sleep or idle the address/data pins and other controls hold their entry levels.
// - In sleep or idle chip enable and both byte selects are driven high.
// - On the small package the bus control register is absent and reads as zero.
// - Unimplemented register bits ignore writes and read as zero.
// - Bus enabled with internal execution: data floats, strobes high, latch and byte address low.
// - In every external mode the bus owns its shared pins ahead of other functions.
// - The two-bit write configuration selects byte write, word write or byte select.
module ext_bus_power_mode_control
  import ext_bus_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0,
  parameter int AD_WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core status
  input wire power_mode_t core_mode,
  input wire logic ext_exec,
  // Core access request
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [AD_WIDTH-1:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  output logic acc_ready,
  output logic acc_done,
  output logic [AD_WIDTH-1:0] acc_rdata,
  // External bus pins
  input wire logic [AD_WIDTH-1:0] ad_in,
  output logic [AD_WIDTH-1:0] ad_out,
  output logic ad_oe,
  output logic ale,
  output logic oe_n,
  output logic wrh_n,
  output logic wrl_n,
  output logic ce_n,
  output logic low_byte_select_n,
  output logic high_byte_select_n,
  output logic byte_addr_lsb,
  output logic pins_owned
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  if (AD_WIDTH != 16) begin : g_width_check
    $error("AD_WIDTH must be 16");
  end

  localparam int TIMER_W = 3;

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [7:0] ext_bus_control;
  logic [7:0] port_pullup_config;
  logic [7:0] module_power_disable_four;
  logic bus_disable_bit;
  logic [WAIT_COUNT_W-1:0] wait_count;
  logic [WRITE_CFG_W-1:0] write_cfg_field;
  logic membus_module_off;

  // Writes keep only implemented bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_bus_control <= EXT_BUS_CONTROL_RESET;
      port_pullup_config <= PORT_PULLUP_CONFIG_RESET;
      module_power_disable_four <= MODULE_POWER_DISABLE_FOUR_RESET;
    end else if (reg_wr) begin
      if (reg_addr == REG_EXT_BUS_CONTROL) begin
        if (!SMALL_PACKAGE) begin
          ext_bus_control <= reg_wdata & EXT_BUS_CONTROL_MASK;
        end
      end else if (reg_addr == REG_PORT_PULLUP_CONFIG) begin
        port_pullup_config <= reg_wdata & PORT_PULLUP_CONFIG_MASK;
      end else if (reg_addr == REG_MODULE_POWER_DISABLE_FOUR) begin
        module_power_disable_four <= reg_wdata & MODULE_POWER_DISABLE_FOUR_MASK;
      end
    end
  end

  // Read data stand for the one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == REG_EXT_BUS_CONTROL) begin
        reg_rdata <= SMALL_PACKAGE ? 8'h00 : ext_bus_control;
      end else if (reg_addr == REG_PORT_PULLUP_CONFIG) begin
        reg_rdata <= port_pullup_config;
      end else if (reg_addr == REG_MODULE_POWER_DISABLE_FOUR) begin
        reg_rdata <= module_power_disable_four;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Field extraction
  assign bus_disable_bit = ext_bus_control[BUS_DISABLE_BIT];
  assign wait_count = ext_bus_control[WAIT_COUNT_LSB +: WAIT_COUNT_W];
  assign write_cfg_field = ext_bus_control[WRITE_CFG_LSB +: WRITE_CFG_W];
  assign membus_module_off = module_power_disable_four[MEMBUS_MODULE_OFF_BIT];

  // ***************************************************************
  // Mode decode
  // ***************************************************************
  logic sleeping;
  logic bus_enabled;
  logic bus_active;

  // Sleep and idle both suspend the bus; both run modes keep it going
  assign sleeping = (core_mode == MODE_IDLE) || (core_mode == MODE_SLEEP);
  assign bus_enabled = !bus_disable_bit && !membus_module_off && !SMALL_PACKAGE;
  assign bus_active = bus_enabled && ext_exec;
  assign pins_owned = bus_enabled;

  // ***************************************************************
  // Bus cycle sequencer
  // ***************************************************************
  bus_state_t state;
  bus_state_t next_state;
  logic take;
  logic cyc_write;
  logic [AD_WIDTH-1:0] cyc_addr;
  logic [7:0] cyc_wdata;
  logic [7:0] hold_latch;
  logic wake_hold;
  logic timer_load;
  logic [TIMER_W-1:0] timer_value;
  logic timer_expired;
  logic [AD_WIDTH-1:0] ad_sync;

  // No request is taken while suspended
  assign acc_ready = (state == BUS_IDLE) && !sleeping && bus_active;
  assign take = acc_req && acc_ready;

  // Next state; everything freezes while suspended
  always_comb begin
    next_state = state;
    if (sleeping) begin
      next_state = state;
    end else if (!bus_active) begin
      next_state = BUS_IDLE;
    end else begin
      case (state)
        BUS_IDLE: begin
          if (take) begin
            next_state = BUS_ADDR;
          end
        end
        BUS_ADDR: begin
          next_state = BUS_DATA;
        end
        BUS_DATA: begin
          if (timer_expired) begin
            next_state = BUS_IDLE;
          end
        end
        default: begin
          next_state = BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Captures the request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_write <= 1'b0;
      cyc_addr <= '0;
      cyc_wdata <= 8'h00;
    end else if (take) begin
      cyc_write <= acc_write;
      cyc_addr <= acc_addr;
      cyc_wdata <= acc_wdata;
    end
  end

  // Data phase length in core clocks; reads wait out the input sync
  assign timer_load = (state == BUS_ADDR) && !sleeping;
  assign timer_value = cyc_write ? TIMER_W'(wait_count)
                                 : TIMER_W'(wait_count) + TIMER_W'(READ_SYNC_CYCLES);

  phase_timer #(
    .WIDTH(TIMER_W)
  ) u_phase_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(timer_load),
    .load_value(timer_value),
    .hold(sleeping),
    .expired(timer_expired)
  );

  input_sync #(
    .WIDTH(AD_WIDTH)
  ) u_ad_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(ad_in),
    .sync_out(ad_sync)
  );

  // Completion pulse with read data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_done <= 1'b0;
      acc_rdata <= '0;
    end else begin
      acc_done <= (state == BUS_DATA) && (next_state == BUS_IDLE) && !sleeping;
      if ((state == BUS_DATA) && timer_expired && !sleeping && !cyc_write) begin
        acc_rdata <= ad_sync;
      end
    end
  end

  // Word write holding latch for even addresses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_latch <= 8'h00;
    end else if (timer_load && cyc_write && write_cfg_field == WCFG_WORD_WRITE
                 && !cyc_addr[0]) begin
      hold_latch <= cyc_wdata;
    end
  end

  // Pins stay frozen after wake until the next access begins or the bus goes inactive
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_hold <= 1'b0;
    end else if (sleeping) begin
      wake_hold <= 1'b1;
    end else if (take || !bus_active || state != BUS_IDLE) begin
      wake_hold <= 1'b0; // a resumed cycle also releases the frozen levels
    end
  end

  // ***************************************************************
  // Pin drive
  // ***************************************************************
  logic [AD_WIDTH-1:0] next_ad_out;
  logic next_ad_oe;
  logic next_ale;
  logic next_oe_n;
  logic next_wrh_n;
  logic next_wrl_n;
  logic next_ce_n;
  logic next_low_sel_n;
  logic next_high_sel_n;
  logic next_byte_lsb;

  // Pin levels for the coming cycle
  always_comb begin
    next_ad_out = ad_out;
    next_ad_oe = ad_oe;
    next_ale = ale;
    next_oe_n = oe_n;
    next_wrh_n = wrh_n;
    next_wrl_n = wrl_n;
    next_ce_n = ce_n;
    next_low_sel_n = low_byte_select_n;
    next_high_sel_n = high_byte_select_n;
    next_byte_lsb = byte_addr_lsb;
    if (sleeping) begin
      // Everything else holds its entry level
      next_ce_n = 1'b1;
      next_low_sel_n = 1'b1;
      next_high_sel_n = 1'b1;
    end else if (!bus_active || (wake_hold && next_state == BUS_IDLE && bus_active)) begin
      if (!bus_active || !wake_hold) begin
        // Internal execution: float data, strobes high, latch low
        next_ad_oe = 1'b0;
        next_ale = 1'b0;
        next_byte_lsb = 1'b0;
        next_oe_n = 1'b1;
        next_wrh_n = 1'b1;
        next_wrl_n = 1'b1;
        next_ce_n = 1'b1;
        next_low_sel_n = 1'b1;
        next_high_sel_n = 1'b1;
      end
      // Otherwise the frozen levels stand
    end else begin
      case (next_state)
        BUS_ADDR: begin
          next_ad_out = acc_addr;
          next_ad_oe = 1'b1;
          next_ale = 1'b1;
          next_byte_lsb = acc_addr[0];
          next_ce_n = 1'b0;
          next_oe_n = 1'b1;
          next_wrh_n = 1'b1;
          next_wrl_n = 1'b1;
          next_low_sel_n = 1'b1;
          next_high_sel_n = 1'b1;
        end
        BUS_DATA: begin
          next_ale = 1'b0;
          next_ce_n = 1'b0;
          next_byte_lsb = cyc_addr[0];
          if (!cyc_write) begin
            next_ad_oe = 1'b0;
            next_oe_n = 1'b0;
            next_low_sel_n = 1'b0;
            next_high_sel_n = 1'b0;
          end else if (write_cfg_field == WCFG_BYTE_WRITE) begin
            next_ad_out = {cyc_wdata, cyc_wdata};
            next_ad_oe = 1'b1;
            next_wrh_n = !cyc_addr[0];
            next_wrl_n = cyc_addr[0];
            next_low_sel_n = 1'b0;
            next_high_sel_n = 1'b0;
          end else if (write_cfg_field == WCFG_WORD_WRITE) begin
            if (!cyc_addr[0]) begin
              next_ad_oe = 1'b0;
            end else begin
              next_ad_out = {cyc_wdata, hold_latch};
              next_ad_oe = 1'b1;
              next_wrh_n = 1'b0;
              next_low_sel_n = 1'b0;
              next_high_sel_n = 1'b0;
            end
          end else begin
            next_ad_out = {cyc_wdata, cyc_wdata};
            next_ad_oe = 1'b1;
            next_wrh_n = 1'b0;
            next_high_sel_n = !cyc_addr[0];
            next_low_sel_n = cyc_addr[0];
          end
        end
        default: begin
          // Idle between cycles
          next_ad_oe = 1'b0;
          next_ale = 1'b0;
          next_byte_lsb = 1'b0;
          next_oe_n = 1'b1;
          next_wrh_n = 1'b1;
          next_wrl_n = 1'b1;
          next_ce_n = 1'b1;
          next_low_sel_n = 1'b1;
          next_high_sel_n = 1'b1;
        end
      endcase
    end
  end

  // Pin registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_out <= '0;
      ad_oe <= 1'b0;
      ale <= 1'b0;
      oe_n <= 1'b1;
      wrh_n <= 1'b1;
      wrl_n <= 1'b1;
      ce_n <= 1'b1;
      low_byte_select_n <= 1'b1;
      high_byte_select_n <= 1'b1;
      byte_addr_lsb <= 1'b0;
    end else begin
      ad_out <= next_ad_out;
      ad_oe <= next_ad_oe;
      ale <= next_ale;
      oe_n <= next_oe_n;
      wrh_n <= next_wrh_n;
      wrl_n <= next_wrl_n;
      ce_n <= next_ce_n;
      low_byte_select_n <= next_low_sel_n;
      high_byte_select_n <= next_high_sel_n;
      byte_addr_lsb <= next_byte_lsb;
    end
  end

endmodule : ext_bus_power_mode_control

// ---- ext_bus_sva.sv ----
`timescale 1ns/10ps
module ext_bus_sva
  import ext_bus_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0,
  parameter int AD_WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Core side
  input wire power_mode_t core_mode,
  input wire logic ext_exec,
  input wire logic acc_req,
  input wire logic [AD_WIDTH-1:0] acc_addr,
  input wire logic acc_ready,
  input wire logic acc_done,
  // Bus pins
  input wire logic [AD_WIDTH-1:0] ad_out,
  input wire logic ad_oe,
  input wire logic ale,
  input wire logic oe_n,
  input wire logic wrh_n,
  input wire logic wrl_n,
  input wire logic ce_n,
  input wire logic low_byte_select_n,
  input wire logic high_byte_select_n,
  input wire logic byte_addr_lsb,
  input wire logic pins_owned
);
  // ****************
  // Helpers
  // ****************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic slp;

  // Core is in idle or sleep
  assign slp = (core_mode == MODE_IDLE) || (core_mode == MODE_SLEEP);

  // Bits that may read as one at each index
  function automatic logic [7:0] impl_mask(input logic [1:0] a);
    case (a)
      REG_EXT_BUS_CONTROL: return SMALL_PACKAGE ? 8'h00 : EXT_BUS_CONTROL_MASK;
      REG_PORT_PULLUP_CONFIG: return PORT_PULLUP_CONFIG_MASK;
      REG_MODULE_POWER_DISABLE_FOUR: return MODULE_POWER_DISABLE_FOUR_MASK;
      default: return 8'h00;
    endcase
  endfunction : impl_mask

  // ****************
  // Properties
  // ****************
  sel_high_a: assert property (slp |=> ce_n && low_byte_select_n && high_byte_select_n)
    else $error("select pins not high in low power mode");
  pins_frozen_a: assert property (slp |=>
    $stable({ad_out, ad_oe, ale, oe_n, wrh_n, wrl_n, byte_addr_lsb}))
    else $error("bus pins moved in low power mode");
  no_take_a: assert property (slp |-> !acc_ready)
    else $error("access accepted in low power mode");
  no_done_a: assert property (slp |=> !acc_done)
    else $error("access finished in low power mode");
  take_addr_a: assert property (acc_req && acc_ready |=>
    ale && ad_oe && !ce_n && ad_out == $past(acc_addr) && byte_addr_lsb == $past(acc_addr[0]))
    else $error("address phase missing after take");
  internal_idle_a: assert property ((!ext_exec && pins_owned && !slp) [*2] |=>
    !ad_oe && !ale && !byte_addr_lsb
    && oe_n && wrh_n && wrl_n && ce_n && low_byte_select_n && high_byte_select_n)
    else $error("bus pins active during internal execution");
  rd_mask_a: assert property (reg_rd |=>
    (reg_rdata & ~impl_mask($past(reg_addr))) == 8'h00)
    else $error("unimplemented bit read as one");
  own_drop_a: assert property (reg_wr && reg_addr == REG_EXT_BUS_CONTROL
    && reg_wdata[BUS_DISABLE_BIT] |=> !pins_owned && !acc_ready)
    else $error("bus still owns pins after disable");

  // Main scenarios reached
  cover property (slp ##1 !slp);
  cover property (acc_req && acc_ready && core_mode == MODE_RUN_REDUCED);
  cover property (reg_rd && reg_addr == 2'h3);
endmodule : ext_bus_sva

bind ext_bus_power_mode_control ext_bus_sva #(.SMALL_PACKAGE(SMALL_PACKAGE), .AD_WIDTH(AD_WIDTH))
  u_ext_bus_sva (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_mode(core_mode),
  .ext_exec(ext_exec), .acc_req(acc_req), .acc_addr(acc_addr), .acc_ready(acc_ready),
  .acc_done(acc_done), .ad_out(ad_out), .ad_oe(ad_oe), .ale(ale), .oe_n(oe_n), .wrh_n(wrh_n),
  .wrl_n(wrl_n), .ce_n(ce_n), .low_byte_select_n(low_byte_select_n),
  .high_byte_select_n(high_byte_select_n), .byte_addr_lsb(byte_addr_lsb), .pins_owned(pins_owned));

// ---- ext_mem_model.sv ----
`timescale 1ns/10ps
module ext_mem_model (
  // Bus pins from the controller
  input wire logic ref_clk,
  input wire logic [15:0] ad_out,
  input wire logic ale,
  input wire logic oe_n,
  input wire logic ce_n,
  // Data back to the controller
  output logic [15:0] ad_in
);
  logic [15:0] addr = 16'h0000;
  logic [15:0] idle_pat = 16'hA5A5;

  // Latch the address; an undriven bus shows a changing pattern
  always @(posedge ref_clk) begin
    if (ale) begin
      addr <= ad_out;
    end
    idle_pat <= ~idle_pat;
  end

  // Memory drives only while selected and output enabled
  assign ad_in = (!ce_n && !oe_n) ? (addr ^ 16'h5A3C) : idle_pat;
endmodule : ext_mem_model

// ---- tb_ext_bus_power_mode_control.sv ----
`timescale 1ns/10ps
module tb_ext_bus_power_mode_control;
  import ext_bus_pkg::*;
  // ****************
  // Signals
  // ****************
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  power_mode_t core_mode = MODE_RUN;
  logic ext_exec = 1'b1;
  logic acc_req = 1'b0;
  logic acc_write = 1'b0;
  logic [15:0] acc_addr = 16'h0000;
  logic [7:0] acc_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic acc_ready, acc_done, ad_oe, ale, oe_n, wrh_n, wrl_n, ce_n, byte_addr_lsb, pins_owned;
  logic low_byte_select_n, high_byte_select_n;
  logic [15:0] acc_rdata, ad_in, ad_out;
  logic [20:0] seen;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #5 ref_clk = ~ref_clk;

  ext_bus_power_mode_control u_ext_bus_power_mode_control (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_mode(core_mode), .ext_exec(ext_exec), .acc_req(acc_req),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ready(acc_ready),
    .acc_done(acc_done), .acc_rdata(acc_rdata), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
    .ale(ale), .oe_n(oe_n), .wrh_n(wrh_n), .wrl_n(wrl_n), .ce_n(ce_n),
    .low_byte_select_n(low_byte_select_n), .high_byte_select_n(high_byte_select_n),
    .byte_addr_lsb(byte_addr_lsb), .pins_owned(pins_owned));

  ext_mem_model u_ext_mem_model (.ref_clk(ref_clk), .ad_out(ad_out), .ale(ale), .oe_n(oe_n),
    .ce_n(ce_n), .ad_in(ad_in));

  // Record pins while a write strobe is low
  always @(posedge ref_clk) begin
    if (!wrh_n || !wrl_n) begin
      seen <= {1'b1, wrh_n, wrl_n, low_byte_select_n, high_byte_select_n, ad_out};
    end
  end

  // Cut a hang short
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end
  end

  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Hold the request until the edge that takes it
  task automatic start_acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    acc_req <= 1'b1;
    acc_write <= w;
    acc_addr <= a;
    acc_wdata <= d;
    @(negedge ref_clk);
    for (int i = 0; i < 50 && acc_ready !== 1'b1; i++) @(negedge ref_clk);
    @(posedge ref_clk);
    acc_req <= 1'b0;
  endtask : start_acc

  task automatic wait_done(output int n);
    for (n = 0; n < 60 && acc_done !== 1'b1; n++) @(negedge ref_clk);
    chk("acc_done", acc_done, 1'b1);
  endtask : wait_done

  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    logic [7:0] v;
    logic [7:0] msk [4] = '{EXT_BUS_CONTROL_MASK, PORT_PULLUP_CONFIG_MASK,
      MODULE_POWER_DISABLE_FOUR_MASK, 8'h00};
    logic [7:0] rst [4] = '{EXT_BUS_CONTROL_RESET, PORT_PULLUP_CONFIG_RESET,
      MODULE_POWER_DISABLE_FOUR_RESET, 8'h00};
    for (int i = 0; i < 4; i++) begin
      rd(i[1:0], v);
      chk("reg_reset", v, rst[i]);
      wr(i[1:0], 8'hFF);
      rd(i[1:0], v);
      chk("reg_mask", v, msk[i]);
      wr(i[1:0], 8'h00);
    end
    $display("t_regs done");
  endtask : t_regs

  task automatic t_read(input power_mode_t m, input logic [1:0] wt, input logic [15:0] a);
    int n;
    wr(REG_EXT_BUS_CONTROL, {2'b00, wt, 4'h0});
    core_mode <= m;
    start_acc(1'b0, a, 8'h00);
    wait_done(n);
    chk("read_len", n, wt + 5);
    chk("read_data", acc_rdata, a ^ 16'h5A3C);
    $display("t_read done");
  endtask : t_read

  task automatic t_write(input logic [1:0] cfg, input logic [15:0] a, input logic [7:0] d,
      input logic [20:0] exp, input logic [20:0] msk);
    int n;
    wr(REG_EXT_BUS_CONTROL, {6'h00, cfg});
    @(negedge ref_clk);
    seen = '0;
    start_acc(1'b1, a, d);
    wait_done(n);
    chk("write_pins", seen & msk, exp);
    $display("t_write done");
  endtask : t_write

  task automatic t_sleep();
    logic [17:0] frz;
    int n;
    wr(REG_EXT_BUS_CONTROL, 8'h30);
    start_acc(1'b0, 16'h0123, 8'h00);
    core_mode <= MODE_SLEEP;
    @(negedge ref_clk);
    frz = {ad_out, ad_oe, ale};
    repeat (6) @(negedge ref_clk);
    chk("sleep_sel", {ce_n, low_byte_select_n, high_byte_select_n}, 3'b111);
    chk("sleep_pins", {ad_out, ad_oe, ale}, frz);
    chk("sleep_busy", {acc_done, acc_ready}, 2'b00);
    @(posedge ref_clk);
    core_mode <= MODE_RUN;
    wait_done(n);
    chk("wake_data", acc_rdata, 16'h0123 ^ 16'h5A3C);
    chk("wake_idle", {ce_n, oe_n}, 2'b11);
    @(posedge ref_clk);
    core_mode <= MODE_IDLE;
    repeat (4) @(negedge ref_clk);
    chk("idle_sel", {ce_n, low_byte_select_n, high_byte_select_n}, 3'b111);
    $display("t_sleep done");
  endtask : t_sleep

  task automatic t_own();
    @(posedge ref_clk);
    core_mode <= MODE_RUN;
    ext_exec <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("int_pins", {ad_oe, ale, byte_addr_lsb, oe_n, wrh_n, wrl_n, ce_n, low_byte_select_n,
      high_byte_select_n, acc_ready}, 10'h07E);
    @(posedge ref_clk);
    ext_exec <= 1'b1;
    wr(REG_EXT_BUS_CONTROL, 8'h80);
    @(negedge ref_clk);
    chk("owned_off", {pins_owned, acc_ready}, 2'b00);
    wr(REG_EXT_BUS_CONTROL, 8'h00);
    @(negedge ref_clk);
    chk("owned_on", {pins_owned, acc_ready}, 2'b11);
    wr(REG_MODULE_POWER_DISABLE_FOUR, 8'h01);
    @(negedge ref_clk);
    chk("module_off", {pins_owned, acc_ready}, 2'b00);
    wr(REG_MODULE_POWER_DISABLE_FOUR, 8'h00);
    $display("t_own done");
  endtask : t_own

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_read(MODE_RUN, 2'h0, 16'h1234);
    t_read(MODE_RUN_REDUCED, 2'h0, 16'h4321);
    t_read(MODE_RUN_REDUCED, 2'h3, 16'hBEEF);
    t_write(2'h0, 16'h0011, 8'h5E, 21'h145E5E, 21'h1CFFFF);
    t_write(2'h0, 16'h0010, 8'h5E, 21'h185E5E, 21'h1CFFFF);
    t_write(2'h1, 16'h0020, 8'h34, 21'h000000, 21'h100000);
    t_write(2'h1, 16'h0021, 8'h12, 21'h141234, 21'h1CFFFF);
    t_write(2'h2, 16'h0031, 8'h77, 21'h167777, 21'h1FFFFF);
    t_write(2'h3, 16'h0040, 8'h66, 21'h156666, 21'h1FFFFF);
    t_sleep();
    t_own();
    end_of_test();
  end
endmodule : tb_ext_bus_power_mode_control
